// ===== hw/fsp_pkg.sv
package fsp_pkg;

    // ==========================================================
    // Array geometry
    localparam int FLASH_SIZE_KB = 60;
    localparam logic [16:0] FLASH_BASE = 17'h10000 - 17'(FLASH_SIZE_KB * 1024);
    localparam logic [15:0] SECTOR0_BASE = 16'hf000;
    localparam logic [15:0] SECTOR1_BASE = 16'he000;
    localparam int SECTOR_COUNT = (FLASH_SIZE_KB <= 4) ? 1 : ((FLASH_SIZE_KB <= 8) ? 2 : 3);

    // ==========================================================
    // Register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_ADDR = 5'h04;
    localparam logic [4:0] OFS_WDATA = 5'h08;
    localparam logic [4:0] OFS_RDATA = 5'h0c;
    localparam logic [4:0] OFS_STATUS = 5'h10;
    localparam logic [4:0] OFS_KEY = 5'h14;
    localparam logic [4:0] OFS_OPTION = 5'h18;

    // Status field positions
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_UNLOCK_BIT = 1;
    localparam int ST_PROT_BIT = 2;
    localparam int ST_DENY_BIT = 3;
    localparam int ST_VPP_BIT = 4;
    localparam int ST_RANGE_BIT = 5;
    localparam int ST_MODE_LSB = 8;

    // Unlock sequence, values arbitrary
    localparam logic [7:0] KEY_FIRST = 8'h5a;
    localparam logic [7:0] KEY_SECOND = 8'ha5;

    // Reset values
    localparam logic PROT_RESET = 1'b1;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_PROG = 3'b001,
        OP_ERASE_SECTOR = 3'b010,
        OP_ERASE_ALL = 3'b011,
        OP_READ = 3'b100,
        OP_OPTION = 3'b101
    } fsp_op_t;

    typedef enum logic [1:0] {
        MODE_IAP = 2'b00,
        MODE_ICP = 2'b01,
        MODE_TOOL = 2'b10,
        MODE_ICT = 2'b11
    } fsp_mode_t;

    typedef enum logic [2:0] {
        S_BOOT = 3'b000,
        S_IDLE = 3'b001,
        S_RUN = 3'b010,
        S_UNPROT_ERASE = 3'b011
    } fsp_state_t;

    typedef struct packed {
        logic req;
        fsp_op_t op;
        logic [1:0] sector;
        logic [15:0] addr;
        logic [7:0] wdata;
    } fsp_flash_req_t;

    typedef struct packed {
        logic tool_mode;
        logic in_circuit_programming_mode;
        logic in_circuit_test_mode;
        logic vpp_ok;
    } fsp_pins_t;

endpackage

// ===== hw/fsp_top.sv
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Whole-array and single-sector erase supported
// - Byte programming, only with programming voltage present
// - Sector erase touches only the addressed sector
// - Tool and in-circuit programming modes alter everything, options too
// - Application mode alters all sectors but zero
// - Sector count follows array size
// - Sectors zero and one fixed 4K at top
// - Protection blocks every external read path
// - Unprotecting erases whole array first
// - Protection held in option byte bit
// - Protection disables low-voltage detector
// - Unlock key required before program or erase
// - Test mode runs patterns from RAM
module fsp_top import fsp_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Mode and supply pins
    input wire fsp_pins_t pins,
    // Flash array port
    output fsp_flash_req_t flash_req,
    input wire logic flash_done,
    input wire logic [7:0] flash_rdata,
    input wire logic flash_opt_prot,
    // System outputs
    output logic low_voltage_detector_en,
    output logic ext_read_block,
    output logic ram_exec_en
);

    // ==========================================================
    // Functions
    function automatic logic [2:0] sector_of(input logic [15:0] a);
        // {in range, sector}
        if (a >= SECTOR0_BASE) begin
            sector_of = 3'b100;
        end else if (a >= SECTOR1_BASE) begin
            sector_of = (SECTOR_COUNT >= 2) ? 3'b101 : 3'b000;
        end else if ({1'b0, a} >= FLASH_BASE) begin
            sector_of = (SECTOR_COUNT >= 3) ? 3'b110 : 3'b000;
        end else begin
            sector_of = 3'b000;
        end
    endfunction

    function automatic logic [31:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // ==========================================================
    // Pin synchroniser, three stages with agreement filter
    logic [3:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_f_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_reg <= 4'h0;
            pin_s2_reg <= 4'h0;
            pin_s3_reg <= 4'h0;
            pin_f_reg <= 4'h0;
        end else begin
            pin_s1_reg <= pins;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_f_reg <= (pin_s2_reg & pin_s3_reg) | (pin_f_reg & (pin_s2_reg | pin_s3_reg));
        end
    end

    fsp_pins_t pin_f;
    fsp_mode_t mode;
    assign pin_f = pin_f_reg;

    always_comb begin
        if (pin_f.tool_mode) begin
            mode = MODE_TOOL;
        end else if (pin_f.in_circuit_programming_mode) begin
            mode = MODE_ICP;
        end else if (pin_f.in_circuit_test_mode) begin
            mode = MODE_ICT;
        end else begin
            mode = MODE_IAP;
        end
    end

    // ==========================================================
    // Bus slave: one wait state on every access
    logic resp_reg;
    logic [31:0] readdata_reg;
    logic req_any, wr_en;

    assign req_any = avs_read | avs_write;
    assign avs_waitrequest = req_any & ~resp_reg;
    assign wr_en = avs_write & resp_reg;
    assign avs_readdata = readdata_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            resp_reg <= 1'b0;
        end else begin
            resp_reg <= req_any & ~resp_reg;
        end
    end

    // ==========================================================
    // Software registers
    logic [15:0] addr_reg;
    logic [7:0] wdata_reg, rdata_reg;
    logic [2:0] last_cmd_reg;
    logic prot_reg, lvd_req_reg;
    logic key_stage_reg, unlocked_reg;
    logic deny_reg, vpp_err_reg, range_err_reg;
    fsp_state_t state_reg;
    fsp_flash_req_t freq_reg;
    logic [31:0] wmask, merged_addr, merged_wdata;

    assign wmask = be_mask(avs_byteenable);
    assign merged_addr = ({16'h0000, addr_reg} & ~wmask) | (avs_writedata & wmask);
    assign merged_wdata = ({24'h000000, wdata_reg} & ~wmask) | (avs_writedata & wmask);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_reg <= ADDR_RESET;
            wdata_reg <= BYTE_RESET;
        end else if (wr_en && avs_address == OFS_ADDR) begin
            addr_reg <= merged_addr[15:0];
        end else if (wr_en && avs_address == OFS_WDATA) begin
            wdata_reg <= merged_wdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lvd_req_reg <= 1'b0;
        end else if (wr_en && avs_address == OFS_OPTION && avs_byteenable[0]) begin
            lvd_req_reg <= avs_writedata[1];
        end
    end

    // ==========================================================
    // Command grant decode
    logic cmd_wr, opt_wr, key_wr;
    logic [2:0] cmd;
    logic [2:0] sect;
    logic is_alter, ext_mode, full_rights;
    logic grant, deny_set, vpp_set, range_set;
    logic opt_new, opt_grant;

    assign cmd_wr = wr_en && avs_address == OFS_CTRL && avs_byteenable[0];
    assign opt_wr = wr_en && avs_address == OFS_OPTION && avs_byteenable[0];
    assign key_wr = wr_en && avs_address == OFS_KEY && avs_byteenable[0];
    assign cmd = avs_writedata[2:0];
    assign sect = sector_of(addr_reg);
    assign ext_mode = (mode != MODE_IAP);
    assign full_rights = (mode == MODE_TOOL) || (mode == MODE_ICP);
    assign is_alter = (cmd == OP_PROG) || (cmd == OP_ERASE_SECTOR) || (cmd == OP_ERASE_ALL);
    assign opt_new = avs_writedata[0];

    always_comb begin
        grant = 1'b0;
        vpp_set = 1'b0;
        range_set = 1'b0;
        deny_set = 1'b0;
        if (cmd_wr) begin
            if (state_reg != S_IDLE) begin
                deny_set = 1'b1;
            end else if (cmd == OP_READ) begin
                if (!sect[2]) begin
                    range_set = 1'b1;
                end else if (prot_reg && ext_mode) begin
                    deny_set = 1'b1;
                end else begin
                    grant = 1'b1;
                end
            end else if (!is_alter || !unlocked_reg) begin
                deny_set = 1'b1;
            end else if (mode == MODE_ICT) begin
                deny_set = 1'b1;
            end else if (mode == MODE_IAP && (cmd == OP_ERASE_ALL || sect[1:0] == 2'b00)) begin
                deny_set = 1'b1;
            end else if (cmd != OP_ERASE_ALL && !sect[2]) begin
                range_set = 1'b1;
            end else if (cmd == OP_PROG && !pin_f.vpp_ok) begin
                vpp_set = 1'b1;
            end else begin
                grant = 1'b1;
            end
        end
    end

    always_comb begin
        opt_grant = 1'b0;
        if (opt_wr && opt_new != prot_reg) begin
            opt_grant = full_rights && unlocked_reg && state_reg == S_IDLE
                        && pin_f.vpp_ok;
        end
    end

    // ==========================================================
    // Unlock sequence
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            key_stage_reg <= 1'b0;
            unlocked_reg <= 1'b0;
        end else if (cmd_wr || (opt_wr && opt_new != prot_reg)) begin
            // One unlock covers one attempt only
            key_stage_reg <= 1'b0;
            unlocked_reg <= 1'b0;
        end else if (key_wr) begin
            key_stage_reg <= (avs_writedata[7:0] == KEY_FIRST);
            unlocked_reg <= key_stage_reg && (avs_writedata[7:0] == KEY_SECOND);
        end
    end

    // ==========================================================
    // Sticky error flags, set wins over clear
    logic clr_hit;
    logic [31:0] clr_bits;

    assign clr_hit = wr_en && avs_address == OFS_STATUS;
    assign clr_bits = clr_hit ? (avs_writedata & wmask) : 32'h00000000;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            deny_reg <= 1'b0;
            vpp_err_reg <= 1'b0;
            range_err_reg <= 1'b0;
        end else begin
            deny_reg <= (deny_reg & ~clr_bits[ST_DENY_BIT])
                        | deny_set | (opt_wr && opt_new != prot_reg && !opt_grant);
            vpp_err_reg <= (vpp_err_reg & ~clr_bits[ST_VPP_BIT]) | vpp_set;
            range_err_reg <= (range_err_reg & ~clr_bits[ST_RANGE_BIT]) | range_set;
        end
    end

    // ==========================================================
    // Operation sequencer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= S_BOOT;
            freq_reg <= '0;
            prot_reg <= PROT_RESET;
            rdata_reg <= BYTE_RESET;
            last_cmd_reg <= 3'b000;
        end else begin
            unique case (state_reg)
                S_BOOT: begin
                    // Stored option caught after release; protected until then
                    prot_reg <= flash_opt_prot;
                    state_reg <= S_IDLE;
                end
                S_IDLE: begin
                    if (grant) begin
                        last_cmd_reg <= cmd;
                        freq_reg.req <= 1'b1;
                        freq_reg.op <= fsp_op_t'(cmd);
                        freq_reg.sector <= sect[1:0];
                        freq_reg.addr <= addr_reg;
                        freq_reg.wdata <= wdata_reg;
                        state_reg <= S_RUN;
                    end else if (opt_grant && prot_reg && !opt_new) begin
                        // Protection stays on through the wipe
                        last_cmd_reg <= OP_OPTION;
                        freq_reg.req <= 1'b1;
                        freq_reg.op <= OP_ERASE_ALL;
                        freq_reg.sector <= 2'b00;
                        freq_reg.addr <= ADDR_RESET;
                        freq_reg.wdata <= BYTE_RESET;
                        state_reg <= S_UNPROT_ERASE;
                    end else if (opt_grant) begin
                        last_cmd_reg <= OP_OPTION;
                        freq_reg.req <= 1'b1;
                        freq_reg.op <= OP_OPTION;
                        freq_reg.sector <= 2'b00;
                        freq_reg.addr <= ADDR_RESET;
                        freq_reg.wdata <= {7'h00, opt_new};
                        state_reg <= S_RUN;
                    end
                end
                S_UNPROT_ERASE: begin
                    if (flash_done) begin
                        freq_reg.op <= OP_OPTION;
                        freq_reg.wdata <= BYTE_RESET;
                        state_reg <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (flash_done) begin
                        freq_reg.req <= 1'b0;
                        if (freq_reg.op == OP_READ) begin
                            rdata_reg <= flash_rdata;
                        end
                        if (freq_reg.op == OP_OPTION) begin
                            prot_reg <= freq_reg.wdata[0];
                        end
                        state_reg <= S_IDLE;
                    end
                end
                default: begin
                    freq_reg.req <= 1'b0;
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    assign flash_req = freq_reg;

    // ==========================================================
    // Read mux
    logic [31:0] status_word;
    logic [31:0] rd_mux;

    always_comb begin
        status_word = 32'h00000000;
        status_word[ST_BUSY_BIT] = (state_reg != S_IDLE);
        status_word[ST_UNLOCK_BIT] = unlocked_reg;
        status_word[ST_PROT_BIT] = prot_reg;
        status_word[ST_DENY_BIT] = deny_reg;
        status_word[ST_VPP_BIT] = vpp_err_reg;
        status_word[ST_RANGE_BIT] = range_err_reg;
        status_word[ST_MODE_LSB +: 2] = mode;
    end

    always_comb begin
        unique case (avs_address)
            OFS_CTRL: rd_mux = {29'h00000000, last_cmd_reg};
            OFS_ADDR: rd_mux = {16'h0000, addr_reg};
            OFS_WDATA: rd_mux = {24'h000000, wdata_reg};
            // Held byte hidden from external tools when protected
            OFS_RDATA: rd_mux = (prot_reg && ext_mode) ? 32'h00000000
                                : {24'h000000, rdata_reg};
            OFS_STATUS: rd_mux = status_word;
            OFS_OPTION: rd_mux = {30'h00000000, lvd_req_reg, prot_reg};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            readdata_reg <= 32'h00000000;
        end else if (avs_read && !resp_reg) begin
            readdata_reg <= rd_mux;
        end
    end

    // ==========================================================
    // System outputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_voltage_detector_en <= 1'b0;
            ext_read_block <= 1'b1;
            ram_exec_en <= 1'b0;
        end else begin
            low_voltage_detector_en <= lvd_req_reg & ~prot_reg;
            ext_read_block <= prot_reg & ext_mode;
            ram_exec_en <= (mode == MODE_ICT);
        end
    end

endmodule
`default_nettype wire

// ===== tb/fsp_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module fsp_flash_model import fsp_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Array port
    input wire fsp_flash_req_t flash_req,
    input wire logic [3:0] lat,
    output logic flash_done,
    output logic [7:0] flash_rdata,
    output logic flash_opt_prot
);
    logic [7:0] mem [0:65535];
    logic [3:0] cnt;
    int lo;
    int hi;
    // Nonvolatile: contents and option survive reset
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'h5a;
        end
        flash_opt_prot = 1'b1;
        flash_rdata = 8'h00;
    end
    assign lo = (flash_req.sector == 2'h0) ? 32'hf000 :
                ((flash_req.sector == 2'h1) ? 32'he000 : 32'h1000);
    assign hi = (flash_req.sector == 2'h2) ? 32'hdfff : lo + 32'hfff;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 4'h0;
            flash_done <= 1'b0;
        end else if (flash_req.req && !flash_done && cnt == lat) begin
            cnt <= 4'h0;
            flash_done <= 1'b1;
            // Read data is only meaningful in the done cycle
            flash_rdata <= (flash_req.op == OP_READ) ? mem[flash_req.addr] : ~flash_rdata;
            case (flash_req.op)
                OP_PROG: mem[flash_req.addr] <= mem[flash_req.addr] & flash_req.wdata;
                OP_ERASE_SECTOR: for (int i = lo; i <= hi; i++) mem[i] <= 8'hff;
                OP_ERASE_ALL: for (int i = 32'h1000; i < 65536; i++) mem[i] <= 8'hff;
                OP_OPTION: flash_opt_prot <= flash_req.wdata[0];
                default: cnt <= 4'h0;
            endcase
        end else begin
            cnt <= (flash_req.req && !flash_done) ? cnt + 4'h1 : 4'h0;
            flash_done <= 1'b0;
            flash_rdata <= ~flash_rdata;
        end
    end
endmodule
`default_nettype wire

// ===== tb/fsp_top_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module fsp_top_monitor import fsp_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Watched ports
    input wire fsp_pins_t pins,
    input wire fsp_flash_req_t flash_req,
    input wire logic flash_done,
    input wire logic low_voltage_detector_en,
    input wire logic ext_read_block,
    input wire logic ram_exec_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // ==========
    // Helpers
    logic [3:0] appl_cnt;
    logic [2:0] mode_pins;
    logic alter;
    logic [1:0] exp_sec;
    assign mode_pins = {pins.tool_mode, pins.in_circuit_programming_mode,
                        pins.in_circuit_test_mode};
    assign alter = flash_req.op inside {OP_PROG, OP_ERASE_SECTOR, OP_ERASE_ALL};
    assign exp_sec = (flash_req.addr[15:12] == 4'hf) ? 2'h0 :
                     ((flash_req.addr[15:12] == 4'he) ? 2'h1 : 2'h2);

    // Margin of ten cycles covers the pin synchroniser
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            appl_cnt <= 4'h0;
        end else if (mode_pins != 3'h0) begin
            appl_cnt <= 4'h0;
        end else if (appl_cnt != 4'hf) begin
            appl_cnt <= appl_cnt + 4'h1;
        end
    end

    // ==========
    // Assertions
    a_sector0_appl: assert property (
        flash_req.req && !$past(flash_req.req) && alter &&
        (flash_req.addr[15:12] == 4'hf || flash_req.op == OP_ERASE_ALL) |-> appl_cnt < 4'ha)
        else $error("sector zero altered in application mode");
    a_sector_map: assert property (
        flash_req.req && flash_req.op == OP_ERASE_SECTOR |-> flash_req.sector == exp_sec)
        else $error("sector number does not match address");
    a_lvd_prot: assert property (!(low_voltage_detector_en && ext_read_block))
        else $error("detector enabled while protected");
    a_test_exec: assert property ((mode_pins == 3'h1)[*8] |-> ram_exec_en)
        else $error("test mode without ram execution");
    a_test_off: assert property ((!pins.in_circuit_test_mode)[*8] |-> !ram_exec_en)
        else $error("ram execution outside test mode");
    a_prog_vpp: assert property (
        (!pins.vpp_ok)[*8] |-> !(flash_req.req && !$past(flash_req.req) && flash_req.op == OP_PROG))
        else $error("program started without supply");
    a_req_hold: assert property (
        flash_req.req && !flash_done |=> flash_req.req && $stable(flash_req))
        else $error("array request changed before done");
    a_done_drop: assert property (
        flash_done && flash_req.req && flash_req.op != OP_ERASE_ALL |=> !flash_req.req)
        else $error("array request kept after done");
    a_unprot_order: assert property (
        flash_req.req && flash_req.op == OP_OPTION && !flash_req.wdata[0] &&
        !($past(flash_req.req) && $past(flash_req.op) == OP_OPTION)
        |-> $past(flash_req.req) && $past(flash_req.op) == OP_ERASE_ALL)
        else $error("protection cleared without full erase");

    c_option: cover property (flash_req.req && flash_req.op == OP_OPTION);
    c_sector: cover property (flash_done && flash_req.op == OP_ERASE_SECTOR);
    c_test: cover property (ram_exec_en);
endmodule

bind fsp_top fsp_top_monitor i_fsp_top_monitor (
    .clk(clk),
    .arst_n(arst_n),
    .pins(pins),
    .flash_req(flash_req),
    .flash_done(flash_done),
    .low_voltage_detector_en(low_voltage_detector_en),
    .ext_read_block(ext_read_block),
    .ram_exec_en(ram_exec_en)
);
`default_nettype wire

// ===== tb/fsp_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module fsp_top_tb_top import fsp_pkg::*; ();
    logic clk, arst_n, rd, wr, wreq, fdone, fprot, low_voltage_detector, erb, rex;
    logic [4:0] adr;
    logic [31:0] wd, rdat, rdv, st;
    logic [3:0] lat;
    logic [7:0] frd;
    fsp_pins_t pins;
    fsp_flash_req_t freq;
    int err_count, checked;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    fsp_top i_fsp_top (.clk(clk), .arst_n(arst_n), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdat),
        .avs_waitrequest(wreq), .pins(pins), .flash_req(freq), .flash_done(fdone),
        .flash_rdata(frd), .flash_opt_prot(fprot), .low_voltage_detector_en(low_voltage_detector),
        .ext_read_block(erb), .ram_exec_en(rex));
    fsp_flash_model i_fsp_flash_model (.clk(clk), .arst_n(arst_n), .flash_req(freq),
        .lat(lat), .flash_done(fdone), .flash_rdata(frd), .flash_opt_prot(fprot));

    // ==========
    // Common tasks
    task close_out;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function logic [7:0] fm(input logic [15:0] a);
        return i_fsp_flash_model.mem[a];
    endfunction
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        n = 0;
        // Waitrequest and read data are both taken at the accepting edge
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 40);
        rdv = rdat;
        if (wreq !== 1'b0) begin
            err_count++;
            close_out();
        end
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task go(input logic key, input logic [4:0] r, input logic [31:0] v);
        int n;
        if (key) begin
            bus(1'b1, OFS_KEY, {24'h0, KEY_FIRST});
            bus(1'b1, OFS_KEY, {24'h0, KEY_SECOND});
        end
        bus(1'b1, r, v);
        n = 0;
        do begin
            bus(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (rdv[ST_BUSY_BIT] !== 1'b0 && n < 60);
        st = rdv;
        if (n >= 60) begin
            err_count++;
            close_out();
        end
        bus(1'b1, OFS_STATUS, 32'h38);
    endtask
    task cmd(input logic key, input logic [2:0] c, input logic [15:0] a, input logic [7:0] d);
        bus(1'b1, OFS_ADDR, {16'h0, a});
        bus(1'b1, OFS_WDATA, {24'h0, d});
        go(key, OFS_CTRL, {29'h0, c});
    endtask
    task mode(input logic [3:0] p);
        @(posedge clk);
        pins <= fsp_pins_t'(p);
        repeat (8) @(posedge clk);
    endtask

    // ==========
    // Scenarios
    task t_protect;
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("prot", rdv[ST_PROT_BIT], 32'h1);
        chk("xblock", erb, 32'h1);
        cmd(1'b0, 3'h4, 16'hf000, 8'h00);
        chk("denyrd", st[ST_DENY_BIT], 32'h1);
        bus(1'b0, OFS_RDATA, 32'h0);
        chk("rdata", rdv, 32'h0);
        go(1'b0, OFS_OPTION, 32'h3);
        chk("lvd", low_voltage_detector, 32'h0);
    endtask
    task t_unprotect;
        lat <= 4'h3;
        go(1'b1, OFS_OPTION, 32'h2);
        chk("prot", st[ST_PROT_BIT], 32'h0);
        chk("m1000", fm(16'h1000), 32'hff);
        chk("mffff", fm(16'hffff), 32'hff);
        chk("lvd", low_voltage_detector, 32'h1);
        chk("xblock", erb, 32'h0);
    endtask
    task t_prog;
        cmd(1'b1, 3'h1, 16'hf000, 8'h3c);
        cmd(1'b0, 3'h4, 16'hf000, 8'h00);
        bus(1'b0, OFS_RDATA, 32'h0);
        chk("readback", rdv, 32'h3c);
        mode(4'b1000);
        cmd(1'b1, 3'h1, 16'hf001, 8'h00);
        chk("vpp", st[ST_VPP_BIT], 32'h1);
        chk("mf001", fm(16'hf001), 32'hff);
        mode(4'b1001);
        cmd(1'b1, 3'h1, 16'h0800, 8'h00);
        chk("range", st[ST_RANGE_BIT], 32'h1);
    endtask
    task t_sector;
        cmd(1'b1, 3'h1, 16'he010, 8'h11);
        cmd(1'b1, 3'h1, 16'hd000, 8'h22);
        cmd(1'b1, 3'h2, 16'he000, 8'h00);
        chk("me010", fm(16'he010), 32'hff);
        chk("md000", fm(16'hd000), 32'h22);
        chk("mf000", fm(16'hf000), 32'h3c);
    endtask
    task t_iap;
        mode(4'b0001);
        cmd(1'b1, 3'h1, 16'hf002, 8'h00);
        chk("deny0", st[ST_DENY_BIT], 32'h1);
        chk("mf002", fm(16'hf002), 32'hff);
        cmd(1'b1, 3'h1, 16'he002, 8'h07);
        chk("me002", fm(16'he002), 32'h07);
        cmd(1'b0, 3'h1, 16'he003, 8'h00);
        chk("denykey", st[ST_DENY_BIT], 32'h1);
        chk("me003", fm(16'he003), 32'hff);
    endtask
    task t_test;
        mode(4'b0011);
        chk("ramexec", rex, 32'h1);
        cmd(1'b1, 3'h3, 16'h0000, 8'h00);
        chk("denytest", st[ST_DENY_BIT], 32'h1);
        mode(4'b0101);
        chk("ramexec", rex, 32'h0);
    endtask
    task t_erase_all;
        cmd(1'b1, 3'h3, 16'h0000, 8'h00);
        chk("me002", fm(16'he002), 32'hff);
        chk("md000", fm(16'hd000), 32'hff);
        chk("mf000", fm(16'hf000), 32'hff);
        go(1'b1, OFS_OPTION, 32'h3);
        chk("reprot", st[ST_PROT_BIT], 32'h1);
        chk("optbyte", fprot, 32'h1);
        chk("lvdoff", low_voltage_detector, 32'h0);
        chk("xblock", erb, 32'h1);
        bus(1'b0, OFS_RDATA, 32'h0);
        chk("rdmask", rdv, 32'h0);
    endtask

    initial begin
        arst_n = 1'b0;
        adr = 5'h00;
        rd = 1'b0;
        wr = 1'b0;
        wd = 32'h0;
        lat = 4'h0;
        pins = fsp_pins_t'(4'b1001);
        err_count = 0;
        checked = 0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (8) @(posedge clk);
        t_protect();
        t_unprotect();
        t_prog();
        t_sector();
        t_iap();
        t_test();
        t_erase_all();
        close_out();
    end
endmodule
`default_nettype wire
